// ### sdc_params.svh
// constants of the synchronous dram device model: pin widths, opcodes,
// mode-word fields and reset values; included by the device core only
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

`define SDC_ADDR_W    12
`define SDC_DQ_W      16
`define SDC_BANK_W    2
`define SDC_BANKS     4
`define SDC_LANES     2

// {ras_n, cas_n, we_n} with chip select low
`define SDC_OP_MRS    3'h0
`define SDC_OP_REF    3'h1
`define SDC_OP_PRE    3'h2
`define SDC_OP_ACT    3'h3
`define SDC_OP_WR     3'h4
`define SDC_OP_RD     3'h5
`define SDC_OP_BST    3'h6

// mode word fields
`define SDC_MR_BL_LSB 0
`define SDC_MR_BL_MSB 2
`define SDC_MR_CL_LSB 4
`define SDC_MR_CL_MSB 6
`define SDC_MR_WB_BIT 9
`define SDC_BL_PAGE   3'h7
`define SDC_CL2       3'h2
`define SDC_AP_BIT    10

// reset values: latency 3, burst of one
`define SDC_MR_RST    12'h030
`define SDC_CKE_RST   1'h0

`endif

// ### sdc_pkg.sv
// types shared by the synchronous dram device model
// assumes sdc_params.svh holds the numeric constants
package sdc_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    SDC_IDLE  = 2'h0,
    SDC_READ  = 2'h1,
    SDC_WRITE = 2'h2
  } sdc_burst_t;

endpackage

// ### sdc_mem.sv
// byte-lane storage array of the dram model, read data registered
// assumes one access per clock, address and strobes stable at the edge
`timescale 1ns/10ps
module sdc_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 22
) (
  input  wire logic                 clk_in,    // clock
  input  wire logic                 rst_n_in,  // async reset, active low
  input  wire logic [ADDR_W-1:0]    addr_in,   // word address
  input  wire logic [DATA_W/8-1:0]  we_in,     // per-byte write strobes
  input  wire logic                 re_in,     // read strobe
  input  wire logic [DATA_W-1:0]    wdata_in,  // write data
  output logic      [DATA_W-1:0]    rdata_out  // registered read data
);
  genvar g;
  for (g = 0; g < DATA_W / 8; g++) begin : g_lane
    logic [7:0] arr [0:(1 << ADDR_W) - 1];
    logic [7:0] lane_q;
    always_ff @(posedge clk_in) begin
      if (we_in[g]) begin
        arr[addr_in] <= wdata_in[g*8 +: 8];
      end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        lane_q <= 8'h00;
      end else if (re_in) begin
        lane_q <= arr[addr_in];
      end
    end
    assign rdata_out[g*8 +: 8] = lane_q;
  end
endmodule

// ### sdc_core.sv
// synchronous dram device: command decode, bank rows, bursts, read pipe
// assumes the controller keeps all spacing limits; inputs sync to clk_in
`timescale 1ns/10ps
`include "sdc_params.svh"
// Notes on behaviour
// - a read or write may follow another every cycle
// - clock enable low suspends the device one cycle later
// - clock enable high resumes the device one cycle later
// - write byte masks act on the same edge as the data
// - read byte mask floats that output byte two cycles later
// - precharge during read floats outputs after read latency cycles
// - inputs sampled on rising edge; clock enable low freezes state except the byte mask register
// - chip select high ignores commands; mode and rows kept, a running burst goes on
module sdc_core #(
  parameter int ROW_W = 12,  // row address bits
  parameter int COL_W = 8    // column address bits
) (
  input  wire logic                    clk_in,            // clock
  input  wire logic                    rst_n_in,          // async reset, active low
  input  wire logic                    cke_in,            // clock enable
  input  wire sdc_pkg::sdc_cmd_t       cmd_in,            // command pins, active low
  input  wire logic [`SDC_BANK_W-1:0]  bank_in,           // bank select
  input  wire logic [`SDC_ADDR_W-1:0]  addr_in,           // row / column / mode word
  input  wire logic                    low_byte_mask_in,  // lower byte mask
  input  wire logic                    high_byte_mask_in, // upper byte mask
  input  wire logic [`SDC_DQ_W-1:0]    dq_in,             // data pins, input side
  output logic      [`SDC_DQ_W-1:0]    dq_out,            // data pins, output side
  output logic      [`SDC_LANES-1:0]   dq_oe_out,         // per-byte output enable
  output logic                         clock_active_out,  // high while clock enabled
  output logic      [`SDC_BANKS-1:0]   bank_open_out      // banks holding an open row
);
  localparam int MEM_AW = `SDC_BANK_W + ROW_W + COL_W;

  logic                               clk_en_q;
  logic [`SDC_LANES-1:0]              mask_q;
  logic [`SDC_ADDR_W-1:0]             mr_q, mr_d;
  sdc_pkg::sdc_burst_t                st_q, st_d;
  logic [`SDC_BANK_W-1:0]             bank_q, bank_d, i_bank;
  logic [COL_W-1:0]                   col_q, col_d, cnt_q, cnt_d, i_col, i_cnt, msk;
  logic                               ap_q, ap_d, i_ap;
  logic [`SDC_BANKS-1:0][ROW_W-1:0]   row_q, row_d;
  logic [`SDC_BANKS-1:0]              open_q, open_d;
  logic                               v1_q, v1_d, v2_q, v2_d;
  logic [`SDC_DQ_W-1:0]               d2_q, d2_d, dq_q, dq_d, rdata;
  logic [`SDC_LANES-1:0]              oe_q, oe_d, mem_we;
  logic [MEM_AW-1:0]                  mem_addr;
  logic [2:0]                         op;
  logic accept, cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_ref, cmd_mrs, cmd_bst;
  logic pre_hit, col_cmd, issue, i_rd, i_last, cl2, full;

  function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = (code == `SDC_BL_PAGE) ? '1 : COL_W'((32'h1 << code) - 32'h1);
    return m;
  endfunction

  always_comb begin
    op      = {cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
    accept  = clk_en_q && !cmd_in.cs_n;
    cmd_act = accept && (op == `SDC_OP_ACT);
    cmd_rd  = accept && (op == `SDC_OP_RD);
    cmd_wr  = accept && (op == `SDC_OP_WR);
    cmd_pre = accept && (op == `SDC_OP_PRE);
    cmd_ref = accept && (op == `SDC_OP_REF);
    cmd_mrs = accept && (op == `SDC_OP_MRS);
    cmd_bst = accept && (op == `SDC_OP_BST);
    col_cmd = cmd_rd || cmd_wr;
    pre_hit = cmd_pre && (addr_in[`SDC_AP_BIT] || (bank_in == bank_q));
    full    = (mr_q[`SDC_MR_BL_MSB:`SDC_MR_BL_LSB] == `SDC_BL_PAGE);
    msk     = bl_mask(mr_q[`SDC_MR_BL_MSB:`SDC_MR_BL_LSB]);
    cl2     = (mr_q[`SDC_MR_CL_MSB:`SDC_MR_CL_LSB] == `SDC_CL2);
    issue   = col_cmd || (clk_en_q && (st_q != sdc_pkg::SDC_IDLE) && !cmd_bst && !pre_hit);
    i_rd    = col_cmd ? cmd_rd : (st_q == sdc_pkg::SDC_READ);
    i_bank  = col_cmd ? bank_in : bank_q;
    i_col   = col_cmd ? addr_in[COL_W-1:0] : col_q;
    i_cnt   = col_cmd ? '0 : cnt_q;
    i_ap    = col_cmd ? addr_in[`SDC_AP_BIT] : ap_q;
    i_last  = (!i_rd && mr_q[`SDC_MR_WB_BIT]) || (!full && (i_cnt == msk));
    mem_addr = {i_bank, row_q[i_bank], i_col};
    mem_we  = (issue && !i_rd) ? ~{high_byte_mask_in, low_byte_mask_in} : '0;
  end

  always_comb begin
    st_d   = st_q;
    bank_d = bank_q;
    col_d  = col_q;
    cnt_d  = cnt_q;
    ap_d   = ap_q;
    mr_d   = mr_q;
    row_d  = row_q;
    open_d = open_q;
    v1_d   = v1_q;
    v2_d   = v2_q;
    d2_d   = d2_q;
    dq_d   = dq_q;
    oe_d   = oe_q;
    if (clk_en_q) begin
      if (cmd_bst || pre_hit) begin
        st_d = sdc_pkg::SDC_IDLE;
      end
      if (issue) begin
        bank_d = i_bank;
        ap_d   = i_ap;
        cnt_d  = COL_W'(i_cnt + 1'b1);
        col_d  = (i_col & ~msk) | (COL_W'(i_col + 1'b1) & msk);
        st_d   = i_last ? sdc_pkg::SDC_IDLE : (i_rd ? sdc_pkg::SDC_READ : sdc_pkg::SDC_WRITE);
        if (i_last && i_ap) begin
          open_d[i_bank] = 1'b0;
        end
      end
      if (cmd_act) begin
        open_d[bank_in] = 1'b1;
        row_d[bank_in]  = addr_in[ROW_W-1:0];
      end
      if (cmd_pre) begin
        if (addr_in[`SDC_AP_BIT]) begin
          open_d = '0;
        end else begin
          open_d[bank_in] = 1'b0;
        end
      end
      if (cmd_mrs) begin
        mr_d = addr_in;
      end
      // read pipe loads only issued reads and drains after the burst ends
      v1_d = issue && i_rd;
      v2_d = v1_q;
      d2_d = rdata;
      dq_d = cl2 ? rdata : d2_q;
      oe_d = {`SDC_LANES{cl2 ? v1_q : v2_q}} & ~mask_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_en_q <= `SDC_CKE_RST;
      mask_q   <= '0;
      mr_q     <= `SDC_MR_RST;
      st_q     <= sdc_pkg::SDC_IDLE;
      bank_q   <= '0;
      col_q    <= '0;
      cnt_q    <= '0;
      ap_q     <= 1'b0;
      row_q    <= '0;
      open_q   <= '0;
      v1_q     <= 1'b0;
      v2_q     <= 1'b0;
      d2_q     <= '0;
      dq_q     <= '0;
      oe_q     <= '0;
    end else begin
      clk_en_q <= cke_in;
      mask_q   <= {high_byte_mask_in, low_byte_mask_in};
      mr_q     <= mr_d;
      st_q     <= st_d;
      bank_q   <= bank_d;
      col_q    <= col_d;
      cnt_q    <= cnt_d;
      ap_q     <= ap_d;
      row_q    <= row_d;
      open_q   <= open_d;
      v1_q     <= v1_d;
      v2_q     <= v2_d;
      d2_q     <= d2_d;
      dq_q     <= dq_d;
      oe_q     <= oe_d;
    end
  end

  sdc_mem #(
    .DATA_W (`SDC_DQ_W),
    .ADDR_W (MEM_AW)
  ) u_mem (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .addr_in   (mem_addr),
    .we_in     (mem_we),
    .re_in     (issue && i_rd),
    .wdata_in  (dq_in),
    .rdata_out (rdata)
  );

  assign dq_out           = dq_q;
  assign dq_oe_out        = oe_q;
  assign clock_active_out = clk_en_q;
  assign bank_open_out    = open_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_col_every_cycle: assert property (
    col_cmd |-> issue && (i_col == addr_in[COL_W-1:0]) && (i_rd == cmd_rd))
    else $error("column command not issued at once");
  a_cke_enter: assert property ($fell(cke_in) |=> !clock_active_out)
    else $error("suspend not one cycle after clock enable low");
  a_cke_exit: assert property ($rose(cke_in) |=> clock_active_out)
    else $error("resume not one cycle after clock enable high");
  a_write_mask: assert property (
    cmd_wr |-> (mem_we == ~{high_byte_mask_in, low_byte_mask_in}))
    else $error("write byte mask not applied on same edge");
  a_read_mask: assert property (
    low_byte_mask_in ##1 clk_en_q |=> !dq_oe_out[0])
    else $error("masked read byte still driven");
  a_pre_float: assert property (
    (pre_hit && (st_q == sdc_pkg::SDC_READ) && !col_cmd && !cl2)
      ##1 (clk_en_q && !issue) [*2] |=> (dq_oe_out == '0))
    else $error("outputs not floated three cycles after precharge");
  a_suspend_hold: assert property (
    !clk_en_q |=> $stable(st_q) && $stable(col_q) && $stable(dq_q) && $stable(oe_q))
    else $error("state moved while clock disabled");
  a_cs_ignore: assert property (
    cmd_in.cs_n |=> $stable(mr_q) && $stable(row_q))
    else $error("command taken with chip select high");

  c_read_burst: cover property (cmd_rd ##[2:3] (dq_oe_out == 2'h3));
  c_write_burst: cover property (cmd_wr ##1 (st_q == sdc_pkg::SDC_WRITE));
  c_power_down: cover property (!clk_en_q [*3] ##1 clk_en_q);
  c_pre_interrupt: cover property (pre_hit && (st_q == sdc_pkg::SDC_READ));
  c_burst_stop: cover property (cmd_bst && (st_q == sdc_pkg::SDC_READ));
endmodule

// ### sdc_ctl.sv
// controller-side model: clock enable, command, address, masks, data
// assumes the bench queues one pin set per clock edge through issue
`timescale 1ns/10ps
module sdc_ctl (
  input  wire logic         clk_in,   // clock
  input  wire logic         rst_n_in, // async reset, active low
  output sdc_pkg::sdc_cmd_t cmd_out,  // command pins
  output logic              cke_out,  // clock enable
  output logic [1:0]        bank_out, // bank select
  output logic [11:0]       addr_out, // address
  output logic [1:0]        mask_out, // {high, low} byte masks
  output logic [15:0]       dq_out    // write data
);
  // row cycle at 10 ns, rounded up
  localparam int ROW_GAP = 7;
  localparam int SHORT_GAP = 2;
  localparam int MODE_GAP = 2;
  // auto-precharge write data to next activate
  localparam int AP_GAP = 5;
  localparam int POWER_UP = 10000;
  sdc_pkg::sdc_cmd_t nxt_cmd = 4'hf;
  logic [1:0]        nxt_bank = 2'h0;
  logic [11:0]       nxt_addr = 12'h000;
  logic [1:0]        nxt_mask = 2'h0;
  logic [15:0]       nxt_dq = 16'h0000;
  logic              nxt_dv = 1'b0;
  logic              nxt_cke = 1'b1;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {cmd_out, cke_out, bank_out, addr_out, mask_out, dq_out} <= {4'hf, 33'h0};
    end else begin
      {cmd_out, cke_out, bank_out, addr_out} <= {nxt_cmd, nxt_cke, nxt_bank, nxt_addr};
      mask_out <= nxt_mask;
      // data rides on the command edge; a released line shows inverse
      dq_out <= nxt_dv ? nxt_dq : ~dq_out;
      nxt_cmd = 4'hf;
      nxt_mask = 2'h0;
      nxt_dv = 1'b0;
    end
  end
  task automatic issue(input logic [3:0] c, input logic [1:0] b = 2'h0,
                       input logic [11:0] a = 12'h0, input logic [15:0] d = 16'h0,
                       input logic dv = 1'b0, input logic [1:0] m = 2'h0);
    nxt_cmd = c;
    nxt_bank = b;
    nxt_addr = a;
    nxt_dq = d;
    nxt_dv = dv;
    nxt_mask = m;
    @(posedge clk_in);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) issue(4'hf);
  endtask
  // no command through the power-up wait
  task automatic power_up;
    repeat (POWER_UP) @(posedge clk_in);
    #1;
  endtask
endmodule

// ### sdc_core_tb.sv
// self-checking bench for sdc_core: write, masked read, suspend, precharge
// assumes sdc_ctl drives the command side; results judged at the ports
`timescale 1ns/10ps
module sdc_core_tb;
  localparam logic [3:0] MRS = 4'h0;  // cs_n low plus opcode
  localparam logic [3:0] REF = 4'h1;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] BST = 4'h6;
  localparam int LIMIT = 12000;
  logic              clk_in;
  logic              rst_n_in;
  sdc_pkg::sdc_cmd_t cmd;
  logic              cke;
  logic [1:0]        bank;
  logic [11:0]       addr;
  logic [1:0]        mask;
  logic [15:0]       dq_w;
  logic [15:0]       dq_r;
  logic [1:0]        oe;
  logic              active;
  logic [3:0]        bank_open;
  int                err_count = 0;
  int                total_checks = 0;
  int                cycles = 0;
  sdc_ctl u_sdc_ctl (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .cmd_out  (cmd),
    .cke_out  (cke),
    .bank_out (bank),
    .addr_out (addr),
    .mask_out (mask),
    .dq_out   (dq_w)
  );
  sdc_core #(
    .ROW_W (4),
    .COL_W (4)
  ) u_sdc_core (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .cke_in            (cke),
    .cmd_in            (cmd),
    .bank_in           (bank),
    .addr_in           (addr),
    .low_byte_mask_in  (mask[0]),
    .high_byte_mask_in (mask[1]),
    .dq_in             (dq_w),
    .dq_out            (dq_r),
    .dq_oe_out         (oe),
    .clock_active_out  (active),
    .bank_open_out     (bank_open)
  );
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk("oe", 16'(oe), 16'h0);
    chk("active", 16'(active), 16'h0);
    chk("bank_open", 16'(bank_open), 16'h0);
  endtask
  // latency 2, burst 2: masked write, back-to-back reads, read mask
  task automatic t_write_read;
    u_sdc_ctl.issue(MRS, 2'h0, 12'h021);
    u_sdc_ctl.idle(u_sdc_ctl.MODE_GAP);
    u_sdc_ctl.issue(ACT, 2'h1, 12'h003);
    u_sdc_ctl.idle(u_sdc_ctl.SHORT_GAP - 1);
    chk("bank_open", 16'(bank_open), 16'h2);
    u_sdc_ctl.issue(WR, 2'h1, 12'h004, 16'h1234, 1'b1);
    u_sdc_ctl.issue(4'hf, 2'h0, 12'h0, 16'h5678, 1'b1);
    u_sdc_ctl.issue(WR, 2'h1, 12'h004, 16'habcd, 1'b1, 2'h2);
    u_sdc_ctl.issue(4'hf, 2'h0, 12'h0, 16'h0000, 1'b1, 2'h3);
    u_sdc_ctl.issue(RD, 2'h1, 12'h004);
    u_sdc_ctl.issue(RD, 2'h1, 12'h005);
    u_sdc_ctl.issue(4'hf, 2'h0, 12'h0, 16'h0, 1'b0, 2'h2);
    chk("dq", dq_r, 16'h12cd);
    chk("oe", 16'(oe), 16'h3);
    u_sdc_ctl.idle(1);
    chk("dq", dq_r, 16'h5678);
    u_sdc_ctl.idle(1);
    chk("dq_low", 16'(dq_r[7:0]), 16'h00cd);
    chk("oe", 16'(oe), 16'h1);
    u_sdc_ctl.idle(1);
    chk("oe", 16'(oe), 16'h0);
  endtask
  task automatic t_suspend;
    u_sdc_ctl.nxt_cke = 1'b0;
    u_sdc_ctl.idle(1);
    chk("active", 16'(active), 16'h1);
    u_sdc_ctl.idle(1);
    chk("active", 16'(active), 16'h0);
    u_sdc_ctl.issue(ACT, 2'h2, 12'h001);
    u_sdc_ctl.nxt_cke = 1'b1;
    u_sdc_ctl.idle(1);
    chk("active", 16'(active), 16'h0);
    // next command one edge after resume
    u_sdc_ctl.idle(1);
    chk("active", 16'(active), 16'h1);
    u_sdc_ctl.issue(4'hb, 2'h2, 12'h001);
    u_sdc_ctl.idle(2);
    chk("bank_open", 16'(bank_open), 16'h2);
  endtask
  // latency 3, full page read cut by precharge, then refresh
  task automatic t_pre_read;
    u_sdc_ctl.issue(MRS, 2'h0, 12'h037);
    u_sdc_ctl.idle(u_sdc_ctl.MODE_GAP);
    u_sdc_ctl.issue(RD, 2'h1, 12'h004);
    u_sdc_ctl.idle(1);
    u_sdc_ctl.issue(PRE, 2'h1, 12'h000);
    u_sdc_ctl.idle(1);
    chk("dq", dq_r, 16'h12cd);
    chk("oe", 16'(oe), 16'h3);
    u_sdc_ctl.idle(1);
    chk("dq", dq_r, 16'h5678);
    u_sdc_ctl.idle(1);
    chk("oe", 16'(oe), 16'h0);
    chk("bank_open", 16'(bank_open), 16'h0);
    u_sdc_ctl.idle(u_sdc_ctl.SHORT_GAP);
    // refresh spaced by the row cycle
    u_sdc_ctl.issue(REF);
    u_sdc_ctl.idle(u_sdc_ctl.ROW_GAP);
    chk("oe", 16'(oe), 16'h0);
  endtask
  // latency 2 page read cut by burst stop, precharge all, single auto-precharge write
  task automatic t_stop_ap;
    u_sdc_ctl.issue(MRS, 2'h0, 12'h027);
    u_sdc_ctl.idle(u_sdc_ctl.MODE_GAP);
    u_sdc_ctl.issue(ACT, 2'h1, 12'h003);
    u_sdc_ctl.idle(u_sdc_ctl.SHORT_GAP - 1);
    u_sdc_ctl.issue(RD, 2'h1, 12'h004);
    u_sdc_ctl.issue(4'hf, 2'h0, 12'h0, 16'h0, 1'b0, 2'h1);
    u_sdc_ctl.issue(BST);
    chk("dq", dq_r, 16'h12cd);
    chk("oe", 16'(oe), 16'h3);
    u_sdc_ctl.idle(1);
    chk("dq_high", 16'(dq_r[15:8]), 16'h0056);
    chk("oe", 16'(oe), 16'h2);
    u_sdc_ctl.idle(1);
    chk("oe", 16'(oe), 16'h0);
    u_sdc_ctl.issue(PRE, 2'h0, 12'h400);
    u_sdc_ctl.issue(MRS, 2'h0, 12'h221);
    u_sdc_ctl.idle(u_sdc_ctl.MODE_GAP);
    chk("bank_open", 16'(bank_open), 16'h0);
    u_sdc_ctl.issue(ACT, 2'h1, 12'h003);
    u_sdc_ctl.idle(u_sdc_ctl.SHORT_GAP - 1);
    u_sdc_ctl.issue(WR, 2'h1, 12'h406, 16'h9abc, 1'b1);
    u_sdc_ctl.idle(1);
    chk("bank_open", 16'(bank_open), 16'h0);
    u_sdc_ctl.idle(u_sdc_ctl.AP_GAP);
    u_sdc_ctl.issue(ACT, 2'h1, 12'h003);
    u_sdc_ctl.idle(u_sdc_ctl.SHORT_GAP - 1);
    u_sdc_ctl.issue(RD, 2'h1, 12'h006);
    u_sdc_ctl.idle(2);
    chk("dq", dq_r, 16'h9abc);
    chk("oe", 16'(oe), 16'h3);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    repeat (16) @(posedge clk_in);
    t_reset();
    rst_n_in <= 1'b1;
    u_sdc_ctl.power_up();
    chk("active", 16'(active), 16'h1);
    t_write_read();
    t_suspend();
    t_pre_read();
    t_stop_ap();
    end_sim();
  end
endmodule
